// file: verilog/watchdog_pkg.sv
// Package with the register map, field layout and types of the watchdog unit.
`default_nettype none
package watchdog_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_LOAD_VALUE = 12'h000;
  localparam logic [11:0] OFF_COUNT_NOW = 12'h004;
  localparam logic [11:0] OFF_CONTROL = 12'h008;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int CTL_PRESCALE_LSB = 0;
  localparam int CTL_PRESCALE_MSB = 2;
  localparam int CTL_RUN_BIT = 3;
  localparam int CTL_RESET_EN_BIT = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_LOAD_VALUE = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT_NOW = 32'h0000_FFFF;
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;

  // ****************************************************************
  // Bus request carrier
  // ****************************************************************
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage
`default_nettype wire

// file: verilog/watchdog_prescaler.sv
// Prescaler that gives a one-cycle count enable at the selected division ratio.
`timescale 1ns/1ps
`default_nettype none
module watchdog_prescaler #(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control.
  input wire logic run_i,
  input wire logic [2:0] select_i,
  // Tick out.
  output logic tick_o
);

  // Divide by 256 needs eight divider bits; fewer cannot serve code 7.
  if (DIV_WIDTH < 8) begin : g_width_check
    $error("watchdog_prescaler needs at least 8 divider bits");
  end

  logic [DIV_WIDTH-1:0] div_ff;
  logic [DIV_WIDTH-1:0] mask;

  // Ratio 1 for code 0, otherwise 2 to the power of code plus one.
  always_comb begin
    if (select_i == 3'h0) begin
      mask = '0;
    end else begin
      // The shift count is widened first so that code 7 does not wrap to zero.
      mask = DIV_WIDTH'((9'h001 << ({1'b0, select_i} + 4'h1)) - 9'h001);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !run_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_WIDTH'(1);
    end
  end

  assign tick_o = run_i && ((div_ff & mask) == mask);

endmodule
`default_nettype wire

// file: verilog/apb_watchdog_reset_counter.sv
// Watchdog unit: APB slave registers, down-counter and system reset request.
// Contract
// - Load, count and control registers are an APB slave with word access.
// - When enabled and after a load, the 32-bit counter decrements per prescaled tick until zero.
// - Reaching zero unrefreshed raises a system reset request.
// - Control bit 4 gates the reset output on timeout.
// - Control bit 3 starts and stops the counter.
// - Control field 2:0 selects divide by 1, 4, 8 up to 256.
// - Prescaler makes a count enable; the counter steps only on it.
// - Load register is a write-only 32-bit starting count.
// - Count register is read-only, live, and reads 0xFFFF after reset.
`timescale 1ns/1ps
`default_nettype none
module apb_watchdog_reset_counter (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // System reset request.
  output logic system_reset_request_n_o
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  watchdog_pkg::apb_req_t req;
  logic wr_access;
  logic rd_setup;
  logic wr_load;
  logic wr_control;

  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                 addr: paddr_i, wdata: pwdata_i};
  // Writes take effect in the access phase; reads are prepared in setup.
  assign wr_access = req.sel && req.enable && req.write;
  assign rd_setup = req.sel && !req.enable && !req.write;
  assign wr_load = wr_access && (req.addr == watchdog_pkg::OFF_LOAD_VALUE);
  assign wr_control = wr_access && (req.addr == watchdog_pkg::OFF_CONTROL);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] load_value_ff;
  logic [31:0] control_ff;
  logic [31:0] count_ff;
  logic loaded_ff;
  logic tick;
  logic run;
  logic reset_en;
  logic timeout;

  assign run = control_ff[watchdog_pkg::CTL_RUN_BIT];
  assign reset_en = control_ff[watchdog_pkg::CTL_RESET_EN_BIT];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      load_value_ff <= watchdog_pkg::RST_LOAD_VALUE;
    end else if (wr_load) begin
      load_value_ff <= req.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      control_ff <= watchdog_pkg::RST_CONTROL;
    end else if (wr_control) begin
      control_ff <= req.wdata;
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  watchdog_prescaler #(
    .DIV_WIDTH(8)
  ) u_prescaler (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(run),
    .select_i(control_ff[watchdog_pkg::CTL_PRESCALE_MSB:watchdog_pkg::CTL_PRESCALE_LSB]),
    .tick_o(tick)
  );

  // ****************************************************************
  // Counter
  // ****************************************************************
  // The counter only counts after a load, so the reset value of the
  // count register cannot fire a timeout before software has set it up.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count_ff <= watchdog_pkg::RST_COUNT_NOW;
      loaded_ff <= 1'b0;
    end else if (wr_load) begin
      count_ff <= req.wdata;
      loaded_ff <= 1'b1;
    end else if (run && loaded_ff && tick && (count_ff != 32'h0000_0000)) begin
      count_ff <= count_ff - 32'h0000_0001;
    end
  end

  assign timeout = run && loaded_ff && (count_ff == 32'h0000_0000);

  // ****************************************************************
  // Reset request
  // ****************************************************************
  // Once raised it holds: only the system reset, which the request
  // itself causes, returns it high.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      system_reset_request_n_o <= 1'b1;
    end else if (timeout && reset_en) begin
      system_reset_request_n_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (req.addr)
        watchdog_pkg::OFF_COUNT_NOW: prdata_o <= count_ff;
        watchdog_pkg::OFF_CONTROL: prdata_o <= control_ff;
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b1;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= 1'b1;
      pslverr_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verification/wdog_chk.sv
// Port checker of the watchdog unit.
`timescale 1ns/1ps
`default_nettype none
module wdog_chk (
  // Watched ports.
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic system_reset_request_n_o
);
  logic [31:0] ctl_ff;
  logic ld_ff;
  wire logic wr = psel_i && penable_i && pwrite_i;
  wire logic rd = psel_i && !penable_i && !pwrite_i;
  wire logic rq = system_reset_request_n_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge mclk_i) begin
    if (rst_i || (wr && paddr_i == 12'h008)) begin
      ctl_ff <= rst_i ? 32'h0 : pwdata_i;
    end
  end
  // The count only means something once a load has armed it.
  always_ff @(posedge mclk_i) begin
    ld_ff <= !rst_i && (ld_ff || (wr && paddr_i == 12'h000));
  end
  AST_BUS: assert property (pready_o && !pslverr_o) else $error("bad answer");
  AST_HOLE: assert property (rd && paddr_i > 12'h008 |=> prdata_o == 0)
    else $error("hole read");
  AST_WO: assert property (rd && paddr_i == 12'h000 |=> prdata_o == 0)
    else $error("load read");
  AST_FRESH: assert property (rd && paddr_i == 12'h004 && !ld_ff |=> prdata_o == 32'h0000FFFF)
    else $error("count reset");
  AST_CTL: assert property (rd && paddr_i == 12'h008 |=> prdata_o == ctl_ff)
    else $error("control read");
  AST_HOLD: assert property (!rq |=> !rq) else $error("request dropped");
  AST_REL: assert property ($past(rst_i) |-> rq) else $error("request after reset");
  AST_GATE: assert property (rq && !(ctl_ff[4] && ctl_ff[3]) |=> rq)
    else $error("request while gated");
  AST_TMO: assert property (wr && paddr_i == 0 && pwdata_i < 8 && ctl_ff[4:0] == 5'h18
    |-> ##[1:12] !rq) else $error("no timeout");
  COV_TMO: cover property ($fell(rq));
  COV_REFRESH: cover property (wr && paddr_i == 12'h000 && ctl_ff[4]);
  COV_CTL: cover property (rd && paddr_i == 12'h008);
endmodule
bind apb_watchdog_reset_counter wdog_chk i_chk (.*);
`default_nettype wire

// file: verification/wdog_reset_sink.sv
// Model of the system reset logic fed by the watchdog request.
`timescale 1ns/1ps
`default_nettype none
module wdog_reset_sink (
  input wire logic mclk_i,
  input wire logic por_i,
  input wire logic follow_i,
  input wire logic system_reset_request_n_o,
  output logic rst_i
);
  logic hit_ff = 1'b0;
  // Registered so that the released request cannot race its own reset.
  always @(posedge mclk_i) hit_ff <= follow_i && !system_reset_request_n_o;
  assign rst_i = por_i || hit_ff;
endmodule
`default_nettype wire

// file: verification/apb_watchdog_reset_counter_tb_top.sv
// Testbench of the watchdog unit.
`timescale 1ns/1ps
`default_nettype none
module apb_watchdog_reset_counter_tb_top;
  logic mclk_i = 1'b0;
  logic por_i = 1'b1;
  logic follow_i = 1'b0;
  logic rst_i;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic system_reset_request_n_o;
  logic [31:0] v;
  int err_count = 0;
  int checks_done = 0;
  wdog_reset_sink i_sink (.*);
  apb_watchdog_reset_counter i_dut (.*);
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, w, a, d};
    @(negedge mclk_i);
    penable_i = 1'b1;
    @(negedge mclk_i);
    v = prdata_o;
    {psel_i, penable_i} = 2'b00;
  endtask
  task automatic boot();
    @(negedge mclk_i);
    por_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    por_i = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    err_count++;
    results();
  end
  initial begin
    boot();
    acc(1'b0, 12'h004, 32'h0);
    chk("count", v, 32'h0000FFFF);
    acc(1'b1, 12'h000, 32'h64);
    acc(1'b1, 12'h004, 32'h12);
    acc(1'b1, 12'h008, 32'h10);
    acc(1'b0, 12'h000, 32'h0);
    chk("load", v, 32'h0);
    acc(1'b0, 12'h00C, 32'h0);
    chk("hole", v, 32'h0);
    repeat (20) @(negedge mclk_i);
    acc(1'b0, 12'h004, 32'h0);
    chk("stopped", v, 32'h64);
    acc(1'b0, 12'h008, 32'h0);
    chk("control", v, 32'h10);
    $display("registers end");
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 12'h008, 32'h8 + 32'(k));
      acc(1'b1, 12'h000, 32'h3E8);
      repeat (64 << (k == 0 ? 0 : k + 1)) @(negedge mclk_i);
      acc(1'b0, 12'h004, 32'h0);
      chk("prescaled", 32'(v > 32'h3A5 && v < 32'h3AA), 32'h1);
    end
    acc(1'b1, 12'h008, 32'h8);
    acc(1'b1, 12'h000, 32'h3);
    repeat (12) @(negedge mclk_i);
    acc(1'b0, 12'h004, 32'h0);
    chk("gated", {v[31:1], system_reset_request_n_o}, 32'h1);
    $display("counting end");
    boot();
    acc(1'b1, 12'h000, 32'h14);
    acc(1'b1, 12'h008, 32'h18);
    repeat (3) begin
      repeat (8) @(negedge mclk_i);
      acc(1'b1, 12'h000, 32'h14);
    end
    acc(1'b0, 12'h004, 32'h0);
    chk("refresh", {31'(v > 32'h10 && v < 32'h15), system_reset_request_n_o}, 32'h3);
    acc(1'b1, 12'h000, 32'h3);
    for (int i = 0; i < 20 && system_reset_request_n_o; i++) @(negedge mclk_i);
    acc(1'b1, 12'h008, 32'h0);
    repeat (4) @(negedge mclk_i);
    chk("timeout", 32'(system_reset_request_n_o), 32'h0);
    follow_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    acc(1'b0, 12'h004, 32'h0);
    chk("restart", {v[30:0], system_reset_request_n_o}, 32'h0001FFFF);
    $display("timeout end");
    results();
  end
endmodule
`default_nettype wire
